// ---- mrs_link_pkg.sv ----
// Package: shared constants for the mode-register command link
// Assumes: one command clock, 40 MHz, both ends compiled after this file
package mrs_link_pkg;
   // ==========================================================
   // Clock and timing
   localparam int clk_period_ps = 25000;
   localparam int training_entry_delay_ns = 150;
   localparam int training_exit_delay_ns = 150;
   localparam int step_short_ns = 60;
   localparam int step_long_ns = 150;
   localparam int monitor_derate_ns = 10;
   localparam int monitor_per_pf_ns = 15;
   localparam int entry_cycles = (training_entry_delay_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
   localparam int exit_cycles = (training_exit_delay_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
   localparam int short_cycles = (step_short_ns * 1000) / clk_period_ps;
   localparam int long_cycles = (step_long_ns * 1000) / clk_period_ps;
   localparam int per_device_mode_reg_delay = 10;
   localparam int write_latency = 9;
   // ==========================================================
   // Mode register selectors
   localparam logic [2:0] first_mode_register = 3'h1;
   localparam logic [2:0] multipurpose_mode_register = 3'h3;
   localparam logic [2:0] fifth_mode_register = 3'h5;
   localparam logic [2:0] vref_mode_register = 3'h6;
   // ==========================================================
   // Field positions
   localparam int vref_value_msb = 5;
   localparam int vref_range_bit = 6;
   localparam int vref_train_bit = 7;
   localparam int pda_enable_bit = 4;
   localparam int qual_lane_bit = 0;
   localparam int burst_beats = 8;
   localparam logic [13:0] mr_reset_value = 14'h0000;
endpackage

// ---- mrs_link_if.sv ----
// Interface: command and data lanes between controller and memory device
// Assumes: both ends on clk_in, data strobe edges given as beat enables
`timescale 1ns/1ps
interface mrs_link_if;
   logic mrs_valid;
   logic [2:0] mrs_sel;
   logic [13:0] mrs_addr;
   logic dqs_edge;
   logic dq0;
   logic dq0_oe_n;
   logic dq_wire;
   assign dq_wire = dq0_oe_n ? 1'b1 : dq0;
   modport controller (output mrs_valid, output mrs_sel, output mrs_addr, output dqs_edge,
      output dq0, output dq0_oe_n);
   modport device (input mrs_valid, input mrs_sel, input mrs_addr, input dqs_edge,
      input dq_wire);
endinterface

// ---- qual_capture.sv ----
// Capture of the qualifying data bit inside a write-style burst
// Assumes: strobe edge pulses and lane already synchronised to clk_in
`timescale 1ns/1ps
module qual_capture (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic start_in,
   input wire logic edge_in,
   input wire logic lane_in,
   output logic done_out,
   output logic qual_out
);
   typedef struct packed {
      logic busy;
      logic [3:0] edges;
      logic qual;
      logic done;
   } cap_state_type;
   cap_state_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start_in) begin
         s_d.busy = 1'b1;
         s_d.edges = 4'h0;
      end else if (s_q.busy && edge_in) begin
         s_d.edges = s_q.edges + 4'h1;
         if (s_q.edges == 4'h1) begin
            s_d.qual = lane_in;
         end
         if (s_q.edges == 4'(mrs_link_pkg::burst_beats - 1)) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign done_out = s_q.done;
   assign qual_out = s_q.qual;
endmodule

// ---- mrs_device_end.sv ----
// Memory device end: mode-register control for reference training and per-device mode
// Assumes: link lanes come from another party; strobe and data lanes are synchronised here, command lanes used directly
`timescale 1ns/1ps
// Behaviour
// - Reference value from bits 5:0
// - A7 training enable, A6 range select
// - Range bit picks range 1 or 2
// - Controller waits 150 ns after entry
// - Controller waits 150 ns after exit
// - Exit command keeps the old value
// - Settle within 60 or 150 ns
// - Wait step time before disabling training
// - Monitor lengthens step times; not applied here, settle counts stay fixed
// - Write leveling before per-device mode
// - Terminations may be enabled beforehand
// - Multipurpose bit A4 enters per-device mode
// - Lane 0 low executes, high ignores
// - Lane 0 captured with data strobes
// - Only mode-register commands in per-device mode
// - Commands spaced by latency plus delay
// - Exit writes A4 zero, full register
// - No dynamic termination in per-device mode
// - Sample on second strobe edge
// - Controller holds lane 0 stable
module mrs_device_end (
   input wire logic clk_in,
   input wire logic nrst_in,
   mrs_link_if.device link,
   input wire logic term_pin_in,
   output logic [5:0] vref_value_out,
   output logic vref_range_out,
   output logic training_out,
   output logic settling_out,
   output logic per_device_mode_out,
   output logic dynamic_term_en_out,
   output logic term_follow_pin_out,
   output logic [13:0] first_mr_out,
   output logic [13:0] fifth_mr_out,
   output logic [13:0] multipurpose_mr_out
);
   typedef struct packed {
      logic [1:0] dq_sync;
      logic [1:0] edge_sync;
      logic [1:0] term_sync;
      logic held;
      logic [2:0] held_sel;
      logic [13:0] held_addr;
      logic [13:0] mr1;
      logic [13:0] mr3;
      logic [13:0] mr5;
      logic [13:0] mr6;
      logic [7:0] settle;
   } dev_state_type;
   dev_state_type s_q, s_d;
   logic cap_done;
   logic cap_qual;
   logic start_cap;
   logic apply;
   logic [2:0] a_sel;
   logic [13:0] a_addr;
   assign start_cap = link.mrs_valid && s_q.mr3[mrs_link_pkg::pda_enable_bit];
   qual_capture u_cap (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .start_in(start_cap),
      .edge_in(s_q.edge_sync[1]),
      .lane_in(s_q.dq_sync[1]),
      .done_out(cap_done),
      .qual_out(cap_qual)
   );
   always_comb begin
      s_d = s_q;
      s_d.dq_sync = {s_q.dq_sync[0], link.dq_wire};
      s_d.edge_sync = {s_q.edge_sync[0], link.dqs_edge};
      s_d.term_sync = {s_q.term_sync[0], term_pin_in};
      apply = 1'b0;
      a_sel = link.mrs_sel;
      a_addr = link.mrs_addr;
      // ======================================================
      // Command acceptance
      // hold until burst
      if (start_cap) begin
         s_d.held = 1'b1;
         s_d.held_sel = link.mrs_sel;
         s_d.held_addr = link.mrs_addr;
      end else if (link.mrs_valid) begin
         apply = 1'b1;
      end else if (s_q.held && cap_done) begin
         s_d.held = 1'b0;
         a_sel = s_q.held_sel;
         a_addr = s_q.held_addr;
         apply = !cap_qual;
      end
      if (s_q.settle != 8'h00) begin
         s_d.settle = s_q.settle - 8'h01;
      end
      if (apply) begin
         if (a_sel == mrs_link_pkg::first_mode_register) begin
            s_d.mr1 = a_addr;
         end else if (a_sel == mrs_link_pkg::multipurpose_mode_register) begin
            s_d.mr3 = a_addr;
         end else if (a_sel == mrs_link_pkg::fifth_mode_register) begin
            s_d.mr5 = a_addr;
         end else if (a_sel == mrs_link_pkg::vref_mode_register) begin
            s_d.mr6 = a_addr;
            if (a_addr[mrs_link_pkg::vref_range_bit] != s_q.mr6[mrs_link_pkg::vref_range_bit]
               || (a_addr[5:0] - s_q.mr6[5:0] != 6'h01
               && s_q.mr6[5:0] - a_addr[5:0] != 6'h01
               && a_addr[5:0] != s_q.mr6[5:0])) begin
               s_d.settle = 8'(mrs_link_pkg::long_cycles);
            end else if (a_addr[5:0] != s_q.mr6[5:0]) begin
               s_d.settle = 8'(mrs_link_pkg::short_cycles);
            end
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign vref_value_out = s_q.mr6[mrs_link_pkg::vref_value_msb:0];
   assign vref_range_out = s_q.mr6[mrs_link_pkg::vref_range_bit];
   assign training_out = s_q.mr6[mrs_link_pkg::vref_train_bit];
   assign settling_out = s_q.settle != 8'h00;
   assign per_device_mode_out = s_q.mr3[mrs_link_pkg::pda_enable_bit];
   assign dynamic_term_en_out = !s_q.mr3[mrs_link_pkg::pda_enable_bit];
   assign term_follow_pin_out = s_q.mr3[mrs_link_pkg::pda_enable_bit] && s_q.term_sync[1]
      && (s_q.mr1[10:8] != 3'h0);
   assign first_mr_out = s_q.mr1;
   assign fifth_mr_out = s_q.mr5;
   assign multipurpose_mr_out = s_q.mr3;
endmodule

// ---- mrs_controller_end.sv ----
// Controller end: issues mode-register commands and qualifying data bursts
// Assumes: device end on the same clock; user issues one request at a time
`timescale 1ns/1ps
module mrs_controller_end #(
   parameter int extra_wait = 0
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   mrs_link_if.controller link,
   input wire logic req_in,
   input wire logic [2:0] sel_in,
   input wire logic [13:0] addr_in,
   input wire logic skip_in,
   output logic ready_out
);
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_lat = 4'h2,
      st_burst = 4'h4,
      st_wait = 4'h8
   } ctl_phase_type;
   typedef struct packed {
      ctl_phase_type phase;
      logic pda;
      logic train;
      logic qual;
      logic mrs_valid;
      logic [2:0] sel;
      logic [13:0] addr;
      logic [5:0] vref;
      logic [7:0] cnt;
      logic edge_out;
      logic dq_oe_n;
   } ctl_state_type;
   ctl_state_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.mrs_valid = 1'b0;
      s_d.edge_out = 1'b0;
      case (s_q.phase)
         st_idle: begin
            if (req_in) begin
               s_d.mrs_valid = 1'b1;
               s_d.sel = sel_in;
               s_d.addr = addr_in;
               if (sel_in == mrs_link_pkg::vref_mode_register
                  && !addr_in[mrs_link_pkg::vref_train_bit] && s_q.train) begin
                  s_d.addr[5:0] = s_q.vref;
               end
               s_d.qual = skip_in && !(sel_in == mrs_link_pkg::multipurpose_mode_register
                  && !addr_in[mrs_link_pkg::pda_enable_bit]);
               s_d.cnt = 8'(mrs_link_pkg::write_latency);
               s_d.phase = s_q.pda ? st_lat : st_wait;
               if (!s_q.pda) begin
                  s_d.cnt = 8'(mrs_link_pkg::long_cycles + extra_wait);
               end
               if (sel_in == mrs_link_pkg::vref_mode_register) begin
                  s_d.train = addr_in[mrs_link_pkg::vref_train_bit];
                  s_d.vref = addr_in[5:0];
               end
               if (sel_in == mrs_link_pkg::multipurpose_mode_register) begin
                  s_d.pda = addr_in[mrs_link_pkg::pda_enable_bit];
               end
            end
         end
         st_lat: begin
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h01) begin
               s_d.phase = st_burst;
               s_d.cnt = 8'(mrs_link_pkg::burst_beats);
               s_d.dq_oe_n = 1'b0;
            end
         end
         st_burst: begin
            s_d.edge_out = 1'b1;
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h01) begin
               s_d.phase = st_wait;
               s_d.cnt = 8'(mrs_link_pkg::per_device_mode_reg_delay + 4 + extra_wait);
            end
         end
         st_wait: begin
            s_d.dq_oe_n = 1'b1;
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt <= 8'h01) begin
               s_d.phase = st_idle;
            end
         end
         default: begin
            s_d.phase = st_idle;
         end
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s_q <= '0;
         s_q.phase <= st_idle;
         s_q.dq_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   assign ready_out = s_q.phase == st_idle;
   assign link.mrs_valid = s_q.mrs_valid;
   assign link.mrs_sel = s_q.sel;
   assign link.mrs_addr = s_q.addr;
   assign link.dqs_edge = s_q.edge_out;
   assign link.dq0 = s_q.qual;
   assign link.dq0_oe_n = s_q.dq_oe_n;
endmodule

// ---- mrs_link_assertions.sv ----
// Checker: link and device-output properties for the two joined ends
// Assumes: instantiated in the bench beside the link interface
`timescale 1ns/1ps
module mrs_link_assertions (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic mrs_valid,
   input wire logic [2:0] mrs_sel,
   input wire logic [13:0] mrs_addr,
   input wire logic dqs_edge,
   input wire logic dq0,
   input wire logic dq0_oe_n,
   input wire logic [5:0] vref_value_out,
   input wire logic vref_range_out,
   input wire logic training_out,
   input wire logic settling_out,
   input wire logic per_device_mode_out,
   input wire logic dynamic_term_en_out,
   input wire logic term_follow_pin_out,
   input wire logic [13:0] first_mr_out,
   input wire logic [13:0] multipurpose_mr_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ==========================================================
   // Properties
   a_cmd_spacing: assert property (mrs_valid |=> !mrs_valid [*6])
      else $error("commands too close");
   a_vref_apply: assert property (mrs_valid && mrs_sel == 3'h6 && !per_device_mode_out
      |=> vref_value_out == $past(mrs_addr[5:0]) && vref_range_out == $past(mrs_addr[6])
      && training_out == $past(mrs_addr[7])) else $error("vref fields not applied");
   a_mr3_apply: assert property (mrs_valid && mrs_sel == 3'h3 && !per_device_mode_out
      |=> multipurpose_mr_out == $past(mrs_addr)) else $error("mode register not applied");
   a_pda_entry: assert property ($rose(per_device_mode_out) |-> $past(mrs_valid)
      && $past(mrs_sel) == 3'h3 && $past(mrs_addr[4])) else $error("per-device entry uncommanded");
   a_pda_hold: assert property (per_device_mode_out && mrs_valid
      |=> ($stable(multipurpose_mr_out) && $stable(vref_value_out)) [*8])
      else $error("applied before burst");
   a_lane_driven: assert property (dqs_edge |-> !dq0_oe_n)
      else $error("lane not driven in burst");
   a_lane_stable: assert property (dqs_edge && $past(dqs_edge) |-> $stable(dq0))
      else $error("lane moved in burst");
   a_dyn_term: assert property (dynamic_term_en_out == !per_device_mode_out)
      else $error("dynamic termination in per-device mode");
   a_term_pin: assert property (term_follow_pin_out
      |-> per_device_mode_out && first_mr_out[10:8] != 3'h0) else $error("pin follow wrong");
   a_settle_bound: assert property ($rose(settling_out) |-> ##[1:6] !settling_out)
      else $error("settling too long");
   a_settle_start: assert property (mrs_valid && mrs_sel == 3'h6 && !per_device_mode_out
      && mrs_addr[6] != vref_range_out |=> settling_out) else $error("range change not settling");
   c_pda_cmd: cover property (per_device_mode_out && mrs_valid);
   c_lane_high: cover property (dqs_edge && dq0);
   c_settle: cover property ($rose(settling_out));
   c_pda_exit: cover property ($fell(per_device_mode_out));
endmodule

// ---- data_reference_voltage_training_pda_mode_test.sv ----
// Testbench: drives the controller end user side, checks device end outputs
// Assumes: both ends joined by one link interface on one 40 MHz clock
`timescale 1ns/1ps
module data_reference_voltage_training_pda_mode_test;
   typedef struct packed {
      logic [13:0] mr1;
      logic [13:0] mr5;
      logic [13:0] mr3;
      logic [13:0] mr6;
   } note_type;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic req_in = 1'b0;
   logic [2:0] sel_in = 3'h0;
   logic [13:0] addr_in = 14'h0000;
   logic skip_in = 1'b0;
   logic term_pin_in = 1'b0;
   logic ready_out;
   logic ready_prev = 1'b0;
   logic [5:0] vref_value_out;
   logic vref_range_out, training_out, settling_out, per_device_mode_out;
   logic dynamic_term_en_out, term_follow_pin_out;
   logic [13:0] first_mr_out, fifth_mr_out, multipurpose_mr_out;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed = 32'h4c8200ae;
   logic trk_train = 1'b0;
   logic [5:0] trk_vref = 6'h00;
   note_type model = '0;
   note_type notes[$];
   note_type n;
   mrs_link_if link_bus ();
   mrs_controller_end #(.extra_wait(0)) u_mrs_controller_end (.clk_in(clk_in),
      .nrst_in(nrst_in), .link(link_bus), .req_in(req_in), .sel_in(sel_in),
      .addr_in(addr_in), .skip_in(skip_in), .ready_out(ready_out));
   mrs_device_end u_mrs_device_end (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_bus),
      .term_pin_in(term_pin_in), .vref_value_out(vref_value_out),
      .vref_range_out(vref_range_out), .training_out(training_out),
      .settling_out(settling_out), .per_device_mode_out(per_device_mode_out),
      .dynamic_term_en_out(dynamic_term_en_out), .term_follow_pin_out(term_follow_pin_out),
      .first_mr_out(first_mr_out), .fifth_mr_out(fifth_mr_out),
      .multipurpose_mr_out(multipurpose_mr_out));
   mrs_link_assertions u_mrs_link_assertions (.clk_in(clk_in), .nrst_in(nrst_in),
      .mrs_valid(link_bus.mrs_valid), .mrs_sel(link_bus.mrs_sel),
      .mrs_addr(link_bus.mrs_addr), .dqs_edge(link_bus.dqs_edge), .dq0(link_bus.dq0),
      .dq0_oe_n(link_bus.dq0_oe_n), .vref_value_out(vref_value_out),
      .vref_range_out(vref_range_out), .training_out(training_out),
      .settling_out(settling_out), .per_device_mode_out(per_device_mode_out),
      .dynamic_term_en_out(dynamic_term_en_out), .term_follow_pin_out(term_follow_pin_out),
      .first_mr_out(first_mr_out), .multipurpose_mr_out(multipurpose_mr_out));
   // ==========================================================
   // Clock, timeout, verdict
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // Request driver with expected-result note
   task automatic issue(input logic [2:0] sel, input logic [13:0] addr, input logic skip);
      int k;
      logic [13:0] eff;
      k = 0;
      eff = addr;
      while (ready_out !== 1'b1 && k < 200) begin
         @(posedge clk_in);
         #1;
         k++;
      end
      if (sel == 3'h6) begin
         if (!addr[7] && trk_train) begin
            eff[5:0] = trk_vref;
         end
         trk_train = addr[7];
         trk_vref = eff[5:0];
      end
      // lane high ignored, exit always qualified low
      if (!(model.mr3[4] && skip) || (sel == 3'h3 && !addr[4])) begin
         case (sel)
            3'h1: model.mr1 = eff;
            3'h3: model.mr3 = eff;
            3'h5: model.mr5 = eff;
            default: model.mr6 = eff;
         endcase
      end
      notes.push_back(model);
      req_in = 1'b1;
      sel_in = sel;
      addr_in = addr;
      skip_in = skip;
      @(posedge clk_in);
      #1;
      req_in = 1'b0;
      term_pin_in = 1'($random(seed));
   endtask
   // ==========================================================
   // Monitor: one note for reset, then one per completed request
   initial begin
      forever begin
         @(posedge clk_in);
         #2;
         if (ready_out === 1'b1 && ready_prev !== 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            check(first_mr_out, n.mr1);
            check(fifth_mr_out, n.mr5);
            check(multipurpose_mr_out, n.mr3);
            check({8'h00, vref_value_out}, {8'h00, n.mr6[5:0]});
            check({12'h000, vref_range_out, training_out}, {12'h000, n.mr6[6], n.mr6[7]});
            check({13'h0000, per_device_mode_out}, {13'h0000, n.mr3[4]});
            check({12'h000, dynamic_term_en_out, term_follow_pin_out}, {12'h000, !n.mr3[4],
               n.mr3[4] && term_pin_in && n.mr1[10:8] != 3'h0});
         end
         ready_prev = ready_out;
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [13:0] v;
      int k;
      notes.push_back(model);
      repeat (8) @(posedge clk_in);
      #1;
      nrst_in = 1'b1;
      term_pin_in = 1'b1;
      v = 14'($random(seed));
      v[7] = 1'b1;
      issue(3'h6, v, 1'b0);
      v[5:0] = v[5:0] + 6'h01;
      issue(3'h6, v, 1'b0);
      v[7] = 1'b0;
      issue(3'h6, v, 1'b0);
      v[7] = 1'b1;
      v[6] = ~v[6];
      issue(3'h6, v, 1'b0);
      v = 14'($random(seed));
      v[10:8] = 3'h2;
      issue(3'h1, v, 1'b0);
      issue(3'h5, 14'($random(seed)), 1'b0);
      v = 14'($random(seed));
      v[4] = 1'b1;
      issue(3'h3, v, 1'b0);
      for (k = 0; k < 4; k++) begin
         issue(3'h6, 14'($random(seed)), k[0]);
      end
      // exit with skip set still applies, lane driven low, then full rewrite
      v[4] = 1'b0;
      issue(3'h3, v, 1'b1);
      v = 14'($random(seed));
      v[4] = 1'b0;
      issue(3'h3, v, 1'b0);
      issue(3'h6, 14'($random(seed)), 1'b1);
      k = 0;
      while (notes.size() > 0 && k < 500) begin
         @(posedge clk_in);
         k++;
      end
      if (notes.size() > 0) begin
         miscompares++;
      end
      close_out();
   end
endmodule
